// [include/fifo4_if.sv]
// handshake bundle between the port logic and a four-byte fifo
`timescale 1ns/1ps
interface fifo4_if;
	import spi_status_pkg::*;
	logic              push;
	logic              pop;
	logic              flush;
	logic [BYTE_W-1:0] wdata;
	logic [BYTE_W-1:0] rdata;
	logic [CNT_W-1:0]  count;
	modport user  (output push, pop, flush, wdata, input rdata, count);
	modport store (input push, pop, flush, wdata, output rdata, count);
endinterface

// [include/spi_status_pkg.sv]
// constants, field positions and helpers for the serial port status block
// Summary of operation
// - excess flag set while rx count exceeds threshold
// - status 10:8 shows rx fifo byte count
// - overflow flag set on load into full fifo
// - overflow interrupts unless rx flush is set
// - rx irq flag when bytes received, select clear
// - tx irq flag when bytes sent, select set
// - underflow flag set on start with empty fifo
// - underflow interrupts unless tx flush is set
// - status 3:1 shows tx fifo byte count
// - summary flag set by any port interrupt
// - status read clears sticky and summary flags
// - control register 16 bits, resets to zero
// - control 15:14 pick tx and rx thresholds
// - rx flush ignores incoming data, no rx irq
package spi_status_pkg;
	localparam int          ADDR_W       = 32;
	localparam int          DATA_W       = 16;
	localparam int          BYTE_W       = 8;
	localparam int          CNT_W        = 3;
	localparam int          PTR_W        = 2;
	localparam int          DIV_W        = 6;
	localparam int          FIFO_DEPTH   = 4;
	localparam logic [ADDR_W-1:0] ADDR_STATUS  = 32'hffff0a00;
	localparam logic [ADDR_W-1:0] ADDR_RXBYTE  = 32'hffff0a04;
	localparam logic [ADDR_W-1:0] ADDR_TXBYTE  = 32'hffff0a08;
	localparam logic [ADDR_W-1:0] ADDR_DIV     = 32'hffff0a0c;
	localparam logic [ADDR_W-1:0] ADDR_CTRL    = 32'hffff0a10;
	localparam logic [DATA_W-1:0] CTRL_RESET   = 16'h0000;
	localparam logic [DATA_W-1:0] WORD_ZERO    = 16'h0000;
	localparam logic [DIV_W-1:0]  DIV_RESET    = 6'h00;
	localparam logic [BYTE_W-1:0] BYTE_ZERO    = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_ZERO     = 3'h0;
	localparam logic [CNT_W-1:0]  CNT_ONE      = 3'h1;
	localparam logic [CNT_W-1:0]  CNT_FULL     = 3'h4;
	localparam logic [CNT_W-1:0]  BIT_LAST     = 3'h7;
	localparam logic [PTR_W-1:0]  PTR_ONE      = 2'h1;
	// status field positions
	localparam int ST_RSVD_HI = 15;
	localparam int ST_RSVD_LO = 12;
	localparam int ST_EXCESS  = 11;
	localparam int ST_RXCNT_HI = 10;
	localparam int ST_RXCNT_LO = 8;
	localparam int ST_OVF     = 7;
	localparam int ST_RXIRQ   = 6;
	localparam int ST_TXIRQ   = 5;
	localparam int ST_UNF     = 4;
	localparam int ST_TXCNT_HI = 3;
	localparam int ST_TXCNT_LO = 1;
	localparam int ST_SUM     = 0;
	// control field positions
	localparam int CT_MODE_HI  = 15;
	localparam int CT_MODE_LO  = 14;
	localparam int CT_TXFLUSH  = 13;
	localparam int CT_RXFLUSH  = 12;
	localparam int CT_MISO_OD  = 9;
	localparam int CT_IRQ_TX   = 6;

	// rx threshold for each irq mode code
	function automatic logic [CNT_W-1:0] rx_need(input logic [1:0] mode);
		unique case (mode)
			2'h0, 2'h1: rx_need = 3'h1;
			2'h2:       rx_need = 3'h3;
			2'h3:       rx_need = 3'h4;
		endcase
	endfunction

	// tx threshold: one to four bytes sent
	function automatic logic [CNT_W-1:0] tx_need(input logic [1:0] mode);
		tx_need = {1'b0, mode} + CNT_ONE;
	endfunction
endpackage

// [sim/spi_master_model.sv]
// behavioural serial master that drives the port's slave pins in clock mode 0
`timescale 1ns/1ps
module spi_master_model #(
	parameter int HALF_NS = 80
) (
	output logic      sclk,
	output logic      ss_n,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	// a released line floats to the pull-up level
	wire miso_lvl = miso_oe ? miso : 1'b1;

	// idle: deselected, clock low
	initial begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end

	// one selected byte, msb first; clock stands still outside the frame
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		ss_n = 1'b0;
		#(HALF_NS);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#(HALF_NS);
			sclk = 1'b1;
			rx[i] = miso_lvl;
			#(HALF_NS);
			sclk = 1'b0;
		end
		#(HALF_NS);
		ss_n = 1'b1;
		mosi = ~mosi; // released data must not look like the last bit
	endtask
endmodule // spi_master_model

// [sim/tb_top.sv]
// self-checking bench for the serial port status block
`timescale 1ns/1ps
module tb_top;
	import spi_status_pkg::*;
	logic              ref_clk   = 1'b0;
	logic              rst       = 1'b1;
	logic [ADDR_W-1:0] mmr_addr  = 32'h0;
	logic              mmr_rd    = 1'b0;
	logic              mmr_wr    = 1'b0;
	logic [DATA_W-1:0] mmr_wdata = 16'h0;
	logic [DATA_W-1:0] mmr_rdata;
	logic              sclk, ss_n, mosi, miso_o, miso_oe;
	logic [DATA_W-1:0] st;
	logic [BYTE_W-1:0] rx;
	int                miscompares = 0;
	int                checks = 0;

	always #2 ref_clk = ~ref_clk;

	spi_status_flags u_dut (.ref_clk(ref_clk), .rst(rst), .mmr_addr(mmr_addr),
		.mmr_rd(mmr_rd), .mmr_wr(mmr_wr), .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata),
		.sclk_in(sclk), .ss_n_in(ss_n), .mosi_in(mosi), .miso_o(miso_o), .miso_oe(miso_oe));

	spi_master_model u_master (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_o),
		.miso_oe(miso_oe));

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one strobe cycle; read data is registered at the taking edge
	task automatic bus(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge ref_clk);
		mmr_rd = rd;
		mmr_wr = ~rd;
		mmr_addr = a;
		mmr_wdata = d;
		@(negedge ref_clk);
		mmr_rd = 1'b0;
		mmr_wr = 1'b0;
		st = mmr_rdata;
	endtask

	// expected status word built field by field
	function automatic logic [DATA_W-1:0] sw(logic ex, logic [2:0] rc, logic ov, logic ri,
		logic ti, logic un, logic [2:0] tc, logic sm);
		return {4'h0, ex, rc, ov, ri, ti, un, tc, sm};
	endfunction

	// a frame, then time for sync and flag update
	task automatic frame(input logic [7:0] tx);
		u_master.xfer(tx, rx);
		repeat (12) @(negedge ref_clk);
	endtask

	task automatic t_regs;
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, 16'h0);
		bus(1'b1, ADDR_CTRL, 16'h0);
		check(st, CTRL_RESET);
		bus(1'b0, ADDR_CTRL, 16'hc0c0);
		bus(1'b1, ADDR_CTRL, 16'h0);
		check(st, 16'hc0c0);
		bus(1'b0, ADDR_STATUS, 16'hffff);
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, 16'h0);
		bus(1'b0, ADDR_DIV, 16'h002a);
		bus(1'b1, ADDR_DIV, 16'h0);
		check(st, 16'h002a);
		bus(1'b1, 32'hffff0a14, 16'h0);
		check(st, 16'h0);
		bus(1'b0, ADDR_CTRL, 16'h0);
	endtask

	// fill the tx fifo past full, then flush it
	task automatic t_txcount;
		for (int i = 1; i <= 5; i++) begin
			bus(1'b0, ADDR_TXBYTE, DATA_W'(i));
			bus(1'b1, ADDR_STATUS, 16'h0);
			check(st, sw(0, 0, 0, 0, 0, 0, (i > 4) ? 3'h4 : i[2:0], 0));
		end
		bus(1'b0, ADDR_CTRL, 16'h2000);
		bus(1'b0, ADDR_CTRL, 16'h0);
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, 16'h0);
	endtask

	// rx counts, irq, excess per threshold code, overflow, flush
	task automatic t_rx;
		logic [2:0] need [4] = '{3'h1, 3'h1, 3'h3, 3'h4};
		// tx fifo is empty, so every frame underflows; tx flush keeps that off the summary
		bus(1'b0, ADDR_CTRL, 16'h2000);
		frame(8'h11);
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, sw(0, 1, 0, 1, 0, 1, 0, 1));
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, sw(0, 1, 0, 0, 0, 0, 0, 0));
		for (int i = 2; i <= 4; i++) begin
			frame(8'h20 + i[7:0]);
			bus(1'b1, ADDR_STATUS, 16'h0);
			check(st & 16'h0f80, sw(1, i[2:0], 0, 0, 0, 0, 0, 0));
		end
		for (int m = 0; m < 4; m++) begin
			bus(1'b0, ADDR_CTRL, {m[1:0], 14'h0});
			bus(1'b1, ADDR_STATUS, 16'h0);
			check(st & 16'h0800, {4'h0, (3'h4 > need[m]), 11'h0});
		end
		// mode 3 with tx flush: only the overflow may raise the summary
		bus(1'b0, ADDR_CTRL, 16'he000);
		frame(8'h55);
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st & 16'h0f81, sw(0, 4, 1, 0, 0, 0, 0, 1));
		bus(1'b1, ADDR_RXBYTE, 16'h0);
		check(st & 16'h00ff, 16'h0011);
		bus(1'b0, ADDR_CTRL, 16'h1000);
		frame(8'h66);
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, sw(0, 0, 0, 0, 0, 1, 0, 1));
	endtask

	// underflow with and without tx flush, then tx irq and wire order
	task automatic t_tx;
		frame(8'h00);
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, sw(0, 0, 0, 0, 0, 1, 0, 1));
		bus(1'b0, ADDR_CTRL, 16'h3000);
		frame(8'h00);
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, sw(0, 0, 0, 0, 0, 1, 0, 0));
		// the second byte feeds the load after the eighth fall, so no underflow
		bus(1'b0, ADDR_CTRL, 16'h1040);
		bus(1'b0, ADDR_TXBYTE, 16'h00a5);
		bus(1'b0, ADDR_TXBYTE, 16'h005a);
		frame(8'h00);
		check({8'h0, rx}, 16'h00a5);
		check({15'h0, miso_oe}, 16'h0);
		bus(1'b1, ADDR_STATUS, 16'h0);
		check(st, sw(0, 0, 0, 0, 1, 0, 0, 1));
		// open-drain miso: ones reach the master through the pull-up
		bus(1'b0, ADDR_CTRL, 16'h1200);
		bus(1'b0, ADDR_TXBYTE, 16'h003c);
		frame(8'h00);
		check({8'h0, rx}, 16'h003c);
	endtask

	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// watchdog: the sequence needs well under 100 us
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		t_regs();
		t_txcount();
		t_rx();
		t_tx();
		end_sim();
	end
endmodule // tb_top

// [src/fifo4.sv]
// four-byte fifo with occupancy count and level flush
`timescale 1ns/1ps
module fifo4 (
	input wire logic ref_clk,
	input wire logic rst,
	fifo4_if.store   f
);
	import spi_status_pkg::*;

	logic [BYTE_W-1:0] mem [FIFO_DEPTH];
	logic [PTR_W-1:0]  rd_ptr_r;
	logic [PTR_W-1:0]  wr_ptr_r;
	logic [CNT_W-1:0]  count_r;
	wire               full   = (count_r == CNT_FULL);
	wire               empty  = (count_r == CNT_ZERO);
	wire               do_pop  = f.pop && !empty;
	// a push into a full fifo is dropped; the rx caller flags it as overflow, the tx caller does not flag it
	wire               do_push = f.push && !full;

	assign f.rdata = mem[rd_ptr_r];
	assign f.count = count_r;

	// storage has no reset, only pointers and count do
	always_ff @(posedge ref_clk) begin
		if (do_push && !f.flush) begin
			mem[wr_ptr_r] <= f.wdata;
		end
	end

	// pointers and count; flush holds the fifo empty while set
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_ptr_r <= '0;
			wr_ptr_r <= '0;
			count_r  <= CNT_ZERO;
		end else if (f.flush) begin
			rd_ptr_r <= '0;
			wr_ptr_r <= '0;
			count_r  <= CNT_ZERO;
		end else begin
			if (do_push) wr_ptr_r <= wr_ptr_r + PTR_ONE;
			if (do_pop) rd_ptr_r <= rd_ptr_r + PTR_ONE;
			count_r <= count_r + CNT_W'(do_push) - CNT_W'(do_pop);
		end
	end

	a_fifo_bound: assert property (@(posedge ref_clk) disable iff (rst)
		count_r <= CNT_FULL) else $error("fifo count above depth");
endmodule // fifo4

// [src/spi_status_flags.sv]
// serial port with rx/tx fifos, status flags and control register
`timescale 1ns/1ps
module spi_status_flags (
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	input  wire logic [spi_status_pkg::ADDR_W-1:0] mmr_addr,
	input  wire logic                              mmr_rd,
	input  wire logic                              mmr_wr,
	input  wire logic [spi_status_pkg::DATA_W-1:0] mmr_wdata,
	output logic      [spi_status_pkg::DATA_W-1:0] mmr_rdata,
	input  wire logic                              sclk_in,
	input  wire logic                              ss_n_in,
	input  wire logic                              mosi_in,
	output logic                                   miso_o,
	output logic                                   miso_oe
);
	import spi_status_pkg::*;

	fifo4_if rxf ();
	fifo4_if txf ();

	fifo4 u_rx_fifo (.ref_clk(ref_clk), .rst(rst), .f(rxf.store));
	fifo4 u_tx_fifo (.ref_clk(ref_clk), .rst(rst), .f(txf.store));

	// registers
	logic [DATA_W-1:0] ctrl_r;
	logic [DIV_W-1:0]  div_r;
	logic              ovf_r, rxirq_r, txirq_r, unf_r, sum_r;
	logic [DATA_W-1:0] mmr_rdata_r;
	logic [CNT_W-1:0]  tx_sent_r;
	// link side
	logic              sclk_m, sclk_s, sclk_d;
	logic              ss_m, ss_s, ss_d;
	logic              mosi_m, mosi_s;
	logic [CNT_W-1:0]  bit_cnt_r;
	logic [BYTE_W-1:0] rx_sh_r, tx_sh_r;
	logic              miso_r, miso_oe_r;

	// bus decode
	wire sel_status = (mmr_addr == ADDR_STATUS);
	wire sel_rx     = (mmr_addr == ADDR_RXBYTE);
	wire sel_tx     = (mmr_addr == ADDR_TXBYTE);
	wire sel_div    = (mmr_addr == ADDR_DIV);
	wire sel_ctrl   = (mmr_addr == ADDR_CTRL);
	wire st_read    = mmr_rd && sel_status;

	// control fields
	wire [1:0] irq_mode = ctrl_r[CT_MODE_HI:CT_MODE_LO];
	wire       tx_flush = ctrl_r[CT_TXFLUSH];
	wire       rx_flush = ctrl_r[CT_RXFLUSH];
	wire       miso_od  = ctrl_r[CT_MISO_OD];
	wire       irq_tx   = ctrl_r[CT_IRQ_TX];
	wire [CNT_W-1:0] rx_thr = rx_need(irq_mode);
	wire [CNT_W-1:0] tx_thr = tx_need(irq_mode);

	// link edges, read only from the second sync stage onward
	wire rise      = sclk_s && !sclk_d;
	wire fall      = !sclk_s && sclk_d;
	wire ss_start  = !ss_s && ss_d;
	wire sel_act   = !ss_s;
	wire byte_done = sel_act && rise && (bit_cnt_r == BIT_LAST);
	wire [BYTE_W-1:0] rx_byte = {rx_sh_r[BYTE_W-2:0], mosi_s};
	// a byte load happens at selection and on the fall after each byte
	wire tx_load   = ss_start || (sel_act && fall && (bit_cnt_r == CNT_ZERO));

	// events
	wire rx_full    = (rxf.count == CNT_FULL);
	wire rx_take    = byte_done && !rx_flush;
	wire ovf_evt    = rx_take && rx_full;
	wire [CNT_W-1:0] rx_after = rxf.count + CNT_ONE;
	wire rxirq_evt  = rx_take && !rx_full && !irq_tx && (rx_after == rx_thr);
	wire [CNT_W-1:0] tx_after = tx_sent_r + CNT_ONE;
	wire txirq_evt  = byte_done && irq_tx && (tx_after >= tx_thr);
	wire tx_empty   = (txf.count == CNT_ZERO);
	wire unf_evt    = tx_load && tx_empty;
	// overflow and underflow raise the summary only when not flushing
	wire irq_evt    = rxirq_evt || txirq_evt || (ovf_evt && !rx_flush)
	                  || (unf_evt && !tx_flush);
	wire excess     = (rxf.count > rx_thr);

	// fifo hookup; tx writes are dropped while flushing
	assign rxf.push  = rx_take && !rx_full;
	assign rxf.pop   = mmr_rd && sel_rx;
	assign rxf.flush = rx_flush;
	assign rxf.wdata = rx_byte;
	assign txf.push  = mmr_wr && sel_tx && !tx_flush;
	assign txf.pop   = tx_load && !tx_empty;
	assign txf.flush = tx_flush;
	assign txf.wdata = mmr_wdata[BYTE_W-1:0];

	// status word, reserved bits stay zero
	logic [DATA_W-1:0] status_word;
	always_comb begin
		status_word = WORD_ZERO;
		status_word[ST_EXCESS] = excess;
		status_word[ST_RXCNT_HI:ST_RXCNT_LO] = rxf.count;
		status_word[ST_OVF] = ovf_r;
		status_word[ST_RXIRQ] = rxirq_r;
		status_word[ST_TXIRQ] = txirq_r;
		status_word[ST_UNF] = unf_r;
		status_word[ST_TXCNT_HI:ST_TXCNT_LO] = txf.count;
		status_word[ST_SUM] = sum_r;
	end

	// read mux; unmapped and write-only addresses read zero
	wire [DATA_W-1:0] rd_mux =
		sel_status ? status_word :
		sel_rx     ? {{(DATA_W-BYTE_W){1'b0}}, rxf.rdata} :
		sel_div    ? {{(DATA_W-DIV_W){1'b0}}, div_r} :
		sel_ctrl   ? ctrl_r : WORD_ZERO;

	// software registers; status has no write path
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r      <= CTRL_RESET;
			div_r       <= DIV_RESET;
			mmr_rdata_r <= WORD_ZERO;
		end else begin
			if (mmr_wr && sel_ctrl) ctrl_r <= mmr_wdata;
			if (mmr_wr && sel_div) div_r <= mmr_wdata[DIV_W-1:0];
			if (mmr_rd) mmr_rdata_r <= rd_mux;
		end
	end

	// sticky flags: the event term comes last so a set beats the read clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ovf_r   <= 1'b0;
			rxirq_r <= 1'b0;
			txirq_r <= 1'b0;
			unf_r   <= 1'b0;
			sum_r   <= 1'b0;
		end else begin
			ovf_r   <= (ovf_r && !st_read) || ovf_evt;
			rxirq_r <= (rxirq_r && !st_read) || rxirq_evt;
			txirq_r <= (txirq_r && !st_read) || txirq_evt;
			unf_r   <= (unf_r && !st_read) || unf_evt;
			sum_r   <= (sum_r && !st_read) || irq_evt;
		end
	end

	// bytes sent since the last tx irq
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_sent_r <= CNT_ZERO;
		end else if (byte_done) begin
			tx_sent_r <= (!irq_tx || txirq_evt) ? CNT_ZERO : tx_after;
		end
	end

	// two-stage synchronisers for the link pins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{sclk_m, sclk_s, sclk_d} <= 3'h0;
			{ss_m, ss_s, ss_d}       <= 3'h7;
			{mosi_m, mosi_s}         <= 2'h0;
		end else begin
			{sclk_m, sclk_s, sclk_d} <= {sclk_in, sclk_m, sclk_s};
			{ss_m, ss_s, ss_d}       <= {ss_n_in, ss_m, ss_s};
			{mosi_m, mosi_s}         <= {mosi_in, mosi_m};
		end
	end

	// slave shifter, clock idles low, sample on rise, shift on fall
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_cnt_r <= CNT_ZERO;
			rx_sh_r   <= BYTE_ZERO;
			tx_sh_r   <= BYTE_ZERO;
		end else if (!sel_act) begin
			bit_cnt_r <= CNT_ZERO;
		end else begin
			if (rise) begin
				bit_cnt_r <= bit_cnt_r + CNT_ONE;
				rx_sh_r   <= rx_byte;
			end
			// an empty fifo sends zeros
			if (tx_load) tx_sh_r <= tx_empty ? BYTE_ZERO : txf.rdata;
			else if (fall) tx_sh_r <= {tx_sh_r[BYTE_W-2:0], 1'b0};
		end
	end

	// miso pin; open-drain mode only drives low
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			miso_r    <= 1'b0;
			miso_oe_r <= 1'b0;
		end else begin
			miso_r    <= tx_sh_r[BYTE_W-1];
			miso_oe_r <= sel_act && (!miso_od || !tx_sh_r[BYTE_W-1]);
		end
	end

	assign mmr_rdata = mmr_rdata_r;
	assign miso_o    = miso_r;
	assign miso_oe   = miso_oe_r;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_status_read;
		mmr_rd && sel_status;
	endsequence
	sequence s_quiet;
		!ovf_evt && !rxirq_evt && !txirq_evt && !unf_evt && !irq_evt;
	endsequence

	a_excess_flag: assert property (s_status_read |=>
		mmr_rdata[ST_EXCESS] == ($past(rxf.count) > $past(rx_thr)))
		else $error("excess flag does not match count");
	a_rx_count: assert property (s_status_read |=>
		mmr_rdata[ST_RXCNT_HI:ST_RXCNT_LO] == $past(rxf.count))
		else $error("rx count field wrong");
	a_ovf_sets: assert property (byte_done && !rx_flush && rx_full |=> ovf_r)
		else $error("overflow not flagged");
	a_ovf_irq: assert property (byte_done && !rx_flush && rx_full |=> sum_r)
		else $error("overflow raised no summary");
	a_rxirq_sets: assert property (rxirq_evt |=> rxirq_r && sum_r)
		else $error("rx irq not flagged");
	a_txirq_sets: assert property (txirq_evt |=> txirq_r && sum_r)
		else $error("tx irq not flagged");
	a_unf_sets: assert property (tx_load && tx_empty |=> unf_r)
		else $error("underflow not flagged");
	a_unf_masked: assert property (unf_evt && tx_flush
		&& !rxirq_evt && !txirq_evt && !ovf_evt && !sum_r |=> !sum_r)
		else $error("flushed underflow raised summary");
	a_tx_count: assert property (s_status_read |=>
		mmr_rdata[ST_TXCNT_HI:ST_TXCNT_LO] == $past(txf.count))
		else $error("tx count field wrong");
	a_read_clears: assert property (s_status_read ##0 s_quiet |=>
		!ovf_r && !rxirq_r && !txirq_r && !unf_r && !sum_r)
		else $error("status read left a flag set");
	a_set_wins: assert property (s_status_read ##0 ovf_evt |=> ovf_r && sum_r)
		else $error("event lost under read clear");
	a_ctrl_write: assert property (mmr_wr && sel_ctrl |=> ctrl_r == $past(mmr_wdata))
		else $error("control write not stored");
	// the fifo itself must come up empty, not just the rx irq event stay low
	a_flush_ignore: assert property (rx_flush |-> !rxirq_evt ##1 rxf.count == CNT_ZERO)
		else $error("rx data taken while flushing");
	a_rsvd_zero: assert property (s_status_read |=>
		mmr_rdata[ST_RSVD_HI:ST_RSVD_LO] == '0)
		else $error("reserved status bits not zero");
endmodule // spi_status_flags
